// File: hw/event_blinker.sv
// Purpose: Turns event pulses into visible flashes, one flash per event
// Assumes: Events are one-cycle pulses on the module clock
// Notes: Pending events saturate at the counter limit
`timescale 1ns/1ps
`default_nettype none
module event_blinker #(
  parameter int ON_CYCLES = 16,
  parameter int OFF_CYCLES = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic event_in,
  output logic led_out
);
  localparam int W = led_diag_pkg::CNT_W;
  localparam int PW = led_diag_pkg::PEND_W;
  logic [W-1:0] cnt_q, cnt_d;
  logic [PW-1:0] pend_q, pend_d;
  logic on_q, on_d, busy_q, busy_d;

  always_comb begin
    cnt_d = cnt_q;
    pend_d = pend_q;
    on_d = on_q;
    busy_d = busy_q;
    if (event_in && pend_q != {PW{1'b1}}) begin
      pend_d = pend_q + PW'(1);
    end
    if (!busy_q) begin
      if (pend_d != '0) begin
        pend_d = pend_d - PW'(1);
        busy_d = 1'b1;
        on_d = 1'b1;
        cnt_d = '0;
      end
    end else if (on_q) begin
      if (cnt_q == W'(ON_CYCLES - 1)) begin
        on_d = 1'b0;
        cnt_d = '0;
      end else begin
        cnt_d = cnt_q + W'(1);
      end
    end else if (cnt_q == W'(OFF_CYCLES - 1)) begin
      busy_d = 1'b0;
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + W'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q <= '0;
      pend_q <= '0;
      on_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      pend_q <= pend_d;
      on_q <= on_d;
      busy_q <= busy_d;
    end
  end

  assign led_out = on_q;

  a_flash_len: assert property (@(posedge clk_in) disable iff (rst_in) // R17
    on_q |-> cnt_q < W'(ON_CYCLES))
    else $error("flash held longer than its lit time");

endmodule // event_blinker
`default_nettype wire

// File: hw/led_diag.sv
// Purpose: Front-panel diagnostic LED driver with AHB-Lite registers
// Assumes: Status inputs synchronous to clk_in; single word transfers
// Notes: Indicator rules below; register map in the package
// Operation
// (R1) Activity blinks fast when transfers succeed
// (R2) Activity steady on when transfers not established
// (R3) Activity blinks once per second in programming mode
// (R4) Activity dark while transfer attempts fail
// (R5) Fault lamp latches on after diagnostic fault
// (R6) Config lamp flashes per configuration block 255
// (R7) Config lamp steady on for configuration error
// (R8) Config lamp off when idle, no error
// (R9) Backplane lamp off during normal transfers
// (R10) Backplane lamp on when transfers failed
// (R11) Port error lamp off when traffic clean
// (R12) Port error lamp blinks on periodic errors
// (R13) Port error lamp steady on for hard faults
// (R14) Separate send lamp blinks while port sends
// (R15) Separate receive lamp blinks while port receives
// (R16) Combined traffic lamp blinks on either direction
// (R17) Blink patterns come from clock dividers
// (R18) Activity priority: programming, fail, problem, normal
`timescale 1ns/1ps
`default_nettype none
module led_diag #(
  parameter int FAST_HALF = led_diag_pkg::FAST_HALF_CYC,
  parameter int SLOW_HALF = led_diag_pkg::SLOW_HALF_CYC,
  parameter int EVENT_ON = led_diag_pkg::EVENT_ON_CYC,
  parameter int EVENT_OFF = led_diag_pkg::EVENT_OFF_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire led_diag_pkg::module_status_t status_in,
  input wire led_diag_pkg::port_status_t port_one_in,
  input wire led_diag_pkg::port_status_t port_two_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output led_diag_pkg::led_bank_t leds_out,
  output logic irq_out
);
  localparam int W = led_diag_pkg::CNT_W;
  localparam int NP = led_diag_pkg::NUM_PORTS;
  localparam int IW = led_diag_pkg::IRQ_W;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // Blink dividers
  logic [W-1:0] fast_cnt_q, fast_cnt_d, slow_cnt_q, slow_cnt_d;
  logic fast_ph_q, fast_ph_d, slow_ph_q, slow_ph_d;

  always_comb begin
    fast_cnt_d = fast_cnt_q + W'(1);
    fast_ph_d = fast_ph_q;
    slow_cnt_d = slow_cnt_q + W'(1);
    slow_ph_d = slow_ph_q;
    if (fast_cnt_q == W'(FAST_HALF - 1)) begin // R17
      fast_cnt_d = '0;
      fast_ph_d = !fast_ph_q;
    end
    if (slow_cnt_q == W'(SLOW_HALF - 1)) begin // R17
      slow_cnt_d = '0;
      slow_ph_d = !slow_ph_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fast_cnt_q <= '0;
      slow_cnt_q <= '0;
      fast_ph_q <= 1'b0;
      slow_ph_q <= 1'b0;
    end else begin
      fast_cnt_q <= fast_cnt_d;
      slow_cnt_q <= slow_cnt_d;
      fast_ph_q <= fast_ph_d;
      slow_ph_q <= slow_ph_d;
    end
  end

  // Per-event flashes
  logic cfg_flash;
  logic [NP-1:0] err_flash, tx_flash, rx_flash, trf_flash;
  led_diag_pkg::port_status_t ports [NP];
  assign ports[0] = port_one_in;
  assign ports[1] = port_two_in;

  event_blinker #(.ON_CYCLES(EVENT_ON), .OFF_CYCLES(EVENT_OFF)) u_cfg (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .event_in(status_in.cfg_block_valid &&
      status_in.cfg_block_id == led_diag_pkg::CFG_BLOCK_ID), // R6
    .led_out(cfg_flash)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_port
      event_blinker #(.ON_CYCLES(EVENT_ON), .OFF_CYCLES(EVENT_OFF)) u_err (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .event_in(ports[gi].comm_error), // R12
        .led_out(err_flash[gi])
      );
      event_blinker #(.ON_CYCLES(EVENT_ON), .OFF_CYCLES(EVENT_OFF)) u_tx (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .event_in(ports[gi].tx_byte), // R14
        .led_out(tx_flash[gi])
      );
      event_blinker #(.ON_CYCLES(EVENT_ON), .OFF_CYCLES(EVENT_OFF)) u_rx (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .event_in(ports[gi].rx_byte), // R15
        .led_out(rx_flash[gi])
      );
      event_blinker #(.ON_CYCLES(EVENT_ON), .OFF_CYCLES(EVENT_OFF)) u_trf (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .event_in(ports[gi].tx_byte || ports[gi].rx_byte), // R16
        .led_out(trf_flash[gi])
      );
    end
  endgenerate

  // Indicator state
  led_diag_pkg::act_mode_t mode_q, mode_d;
  led_diag_pkg::led_bank_t led_q, led_d;
  logic fault_q, fault_d, combined_q;
  logic cfg_err;
  logic [NP-1:0] hard_err;

  always_comb begin
    cfg_err = status_in.port_cfg_err || status_in.sys_cfg_err;
    for (int i = 0; i < NP; i++) begin
      hard_err[i] = ports[i].cts_missing || cfg_err ||
        ports[i].slave_fail || ports[i].master_recurring;
    end
    fault_d = fault_q || status_in.diag_fault; // R5
    if (status_in.prog_mode) begin
      mode_d = led_diag_pkg::ACT_PROG; // R18
    end else if (status_in.bt_fail) begin
      mode_d = led_diag_pkg::ACT_FAIL;
    end else if (!status_in.bt_ok) begin
      mode_d = led_diag_pkg::ACT_PROBLEM;
    end else begin
      mode_d = led_diag_pkg::ACT_NORMAL;
    end
    led_d = '0;
    unique case (mode_d)
      led_diag_pkg::ACT_PROG: led_d.activity_led = slow_ph_q; // R3
      led_diag_pkg::ACT_FAIL: led_d.activity_led = 1'b0; // R4
      led_diag_pkg::ACT_PROBLEM: led_d.activity_led = 1'b1; // R2
      led_diag_pkg::ACT_NORMAL: led_d.activity_led = fast_ph_q; // R1
    endcase
    led_d.fault_led = fault_d; // R5
    led_d.config_led = cfg_err || cfg_flash; // R7 R8
    led_d.backplane_fail_led = status_in.bt_fail; // R9 R10
    led_d.port_one_error_led = hard_err[0] || err_flash[0]; // R11 R13
    led_d.port_two_error_led = hard_err[1] || err_flash[1]; // R11 R13
    led_d.port_one_send_led = !combined_q && tx_flash[0]; // R14
    led_d.port_two_send_led = !combined_q && tx_flash[1]; // R14
    led_d.port_one_receive_led = !combined_q && rx_flash[0]; // R15
    led_d.port_two_receive_led = !combined_q && rx_flash[1]; // R15
    led_d.port_one_traffic_led = combined_q && trf_flash[0]; // R16
    led_d.port_two_traffic_led = combined_q && trf_flash[1]; // R16
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_q <= led_diag_pkg::ACT_PROBLEM;
      led_q <= '0;
      fault_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      led_q <= led_d;
      fault_q <= fault_d;
    end
  end

  assign leds_out = led_q;

  // Interrupt events
  logic [IW-1:0] irq_stat_q, irq_stat_d, irq_en_q, irq_en_d, irq_set;
  logic [IW-1:0] irq_clr;
  logic irq_q, irq_d, cfg_err_q, bt_fail_q;

  // AHB-Lite slave state
  logic wr_pend_q, wr_pend_d, rd_pend_q, rd_pend_d, ready_q, ready_d;
  logic [7:0] addr_q, addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic combined_d;
  logic take;

  always_comb begin
    irq_set = '0;
    irq_set[led_diag_pkg::IRQ_CFG_BLOCK_BIT] = status_in.cfg_block_valid &&
      status_in.cfg_block_id == led_diag_pkg::CFG_BLOCK_ID;
    irq_set[led_diag_pkg::IRQ_CFG_ERR_BIT] = cfg_err && !cfg_err_q;
    irq_set[led_diag_pkg::IRQ_FAULT_BIT] = status_in.diag_fault && !fault_q;
    irq_set[led_diag_pkg::IRQ_BT_FAIL_BIT] = status_in.bt_fail && !bt_fail_q;
    irq_set[led_diag_pkg::IRQ_PORT_ERR_BIT] = port_one_in.comm_error;
    irq_set[led_diag_pkg::IRQ_PORT_ERR_BIT + 1] = port_two_in.comm_error;
    take = hsel_in && htrans_in[1] && hready_in;
    wr_pend_d = take && hwrite_in;
    rd_pend_d = take && !hwrite_in;
    addr_d = take ? {haddr_in[7:2], 2'b00} : addr_q;
    ready_d = !rd_pend_d;
    combined_d = combined_q;
    irq_en_d = irq_en_q;
    irq_clr = '0;
    if (wr_pend_q) begin
      unique case (addr_q)
        led_diag_pkg::CTRL_OFF:
          combined_d = hwdata_in[led_diag_pkg::CTRL_COMBINED_BIT];
        led_diag_pkg::IRQ_ENABLE_OFF: irq_en_d = hwdata_in[IW-1:0];
        led_diag_pkg::IRQ_CLEAR_OFF: irq_clr = hwdata_in[IW-1:0];
        default: ;
      endcase
    end
    // Set wins over a clear in the same cycle
    irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;
    irq_d = |(irq_stat_q & irq_en_q);
    rdata_d = rdata_q;
    if (rd_pend_q) begin
      unique case (addr_q)
        led_diag_pkg::CTRL_OFF: rdata_d = {31'h0, combined_q};
        led_diag_pkg::LED_STATE_OFF: rdata_d = {20'h0, led_q};
        led_diag_pkg::IRQ_STATUS_OFF: rdata_d = {26'h0, irq_stat_q};
        led_diag_pkg::IRQ_ENABLE_OFF: rdata_d = {26'h0, irq_en_q};
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      ready_q <= 1'b1;
      addr_q <= 8'h00;
      rdata_q <= 32'h0;
      combined_q <= led_diag_pkg::CTRL_COMBINED_RST;
      irq_en_q <= led_diag_pkg::IRQ_RST;
      irq_stat_q <= led_diag_pkg::IRQ_RST;
      irq_q <= 1'b0;
      cfg_err_q <= 1'b0;
      bt_fail_q <= 1'b0;
    end else begin
      wr_pend_q <= wr_pend_d;
      rd_pend_q <= rd_pend_d;
      ready_q <= ready_d;
      addr_q <= addr_d;
      rdata_q <= rdata_d;
      combined_q <= combined_d;
      irq_en_q <= irq_en_d;
      irq_stat_q <= irq_stat_d;
      irq_q <= irq_d;
      cfg_err_q <= cfg_err;
      bt_fail_q <= status_in.bt_fail;
    end
  end

  assign hrdata_out = rdata_q;
  assign hreadyout_out = ready_q;
  assign hresp_out = 1'b0;
  assign irq_out = irq_q;

  a_fast_normal: assert property ( // R1
    status_in.bt_ok && !status_in.bt_fail && !status_in.prog_mode
    |=> leds_out.activity_led == $past(fast_ph_q))
    else $error("activity lamp not following fast blink");
  a_problem_steady: assert property ( // R2
    !status_in.bt_ok && !status_in.bt_fail && !status_in.prog_mode
    |=> leds_out.activity_led)
    else $error("activity lamp not steady on");
  a_prog_slow: assert property ( // R3
    status_in.prog_mode |=> leds_out.activity_led == $past(slow_ph_q))
    else $error("activity lamp not on one hertz blink");
  a_fail_dark: assert property ( // R4
    status_in.bt_fail && !status_in.prog_mode |=> !leds_out.activity_led)
    else $error("activity lamp lit during failing transfers");
  a_fault_sticky: assert property ( // R5
    status_in.diag_fault ##1 1'b1 |=> leds_out.fault_led [*3])
    else $error("fault lamp did not stay on");
  a_cfg_flash: assert property ( // R6
    status_in.cfg_block_valid && status_in.cfg_block_id == 8'hff
    && !cfg_flash |=> ##[0:20] cfg_flash)
    else $error("no flash for configuration block");
  a_cfg_error_on: assert property ( // R7
    status_in.port_cfg_err || status_in.sys_cfg_err |=> leds_out.config_led)
    else $error("config lamp not on for error");
  a_cfg_idle_off: assert property ( // R8
    !cfg_err && !cfg_flash |=> !leds_out.config_led)
    else $error("config lamp lit while idle");
  a_bpl_lamp: assert property ( // R9
    ##1 leds_out.backplane_fail_led == $past(status_in.bt_fail))
    else $error("backplane lamp wrong");
  a_port_hard: assert property ( // R13
    port_two_in.cts_missing || port_two_in.slave_fail
    |=> leds_out.port_two_error_led)
    else $error("port error lamp not steady on");
  a_fast_period: assert property ( // R17
    fast_cnt_q == W'(FAST_HALF - 1) |=> fast_ph_q != $past(fast_ph_q))
    else $error("fast divider did not toggle");
  a_irq_level: assert property (
    |(irq_stat_q & irq_en_q) |=> irq_out)
    else $error("enabled event did not raise the interrupt");
  // Registered mode must be fail whenever transfers fail outside programming mode
  a_mode_prio: assert property ( // R18
    status_in.bt_fail && !status_in.prog_mode
    |=> mode_q == led_diag_pkg::ACT_FAIL)
    else $error("activity priority not applied");
  a_send_gated: assert property ( // R16
    combined_q |=> !leds_out.port_one_send_led
    && !leds_out.port_two_send_led)
    else $error("send lamp lit in combined variant");
  a_traffic_on: assert property ( // R16
    combined_q && trf_flash[1] |=> leds_out.port_two_traffic_led)
    else $error("traffic lamp missed a flash");
  a_err_clean: assert property ( // R11
    !hard_err[0] && !err_flash[0] |=> !leds_out.port_one_error_led)
    else $error("port error lamp lit on clean traffic");
  a_err_blink: assert property ( // R12
    err_flash[0] |=> leds_out.port_one_error_led)
    else $error("port error lamp missed a flash");

endmodule // led_diag
`default_nettype wire

// File: hw/led_diag_pkg.sv
// Purpose: Shared constants and types for the diagnostic LED block
// Assumes: 10 MHz module clock, 32-bit AHB-Lite register access
// Notes: Blink times are in milliseconds, counts derived from the clock
package led_diag_pkg;

  localparam int CLK_HZ = 10_000_000;
  localparam int MS_DIV = 1000;
  // Fast blink half period and the 1 Hz blink half period
  localparam int FAST_HALF_MS = 100;
  localparam int SLOW_HALF_MS = 500;
  // One visible flash per event: lit time, then dark gap
  localparam int EVENT_ON_MS = 50;
  localparam int EVENT_OFF_MS = 50;
  localparam int FAST_HALF_CYC = CLK_HZ / MS_DIV * FAST_HALF_MS;
  localparam int SLOW_HALF_CYC = CLK_HZ / MS_DIV * SLOW_HALF_MS;
  localparam int EVENT_ON_CYC = CLK_HZ / MS_DIV * EVENT_ON_MS;
  localparam int EVENT_OFF_CYC = CLK_HZ / MS_DIV * EVENT_OFF_MS;
  localparam int CNT_W = 24;
  localparam int PEND_W = 4;

  localparam logic [7:0] CFG_BLOCK_ID = 8'hff;
  localparam int NUM_PORTS = 2;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] LED_STATE_OFF = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFF = 8'h08;
  localparam logic [7:0] IRQ_ENABLE_OFF = 8'h0c;
  localparam logic [7:0] IRQ_CLEAR_OFF = 8'h10;
  localparam int CTRL_COMBINED_BIT = 0;
  localparam logic CTRL_COMBINED_RST = 1'b0;

  // Interrupt status bit positions
  localparam int IRQ_W = 6;
  localparam int IRQ_CFG_BLOCK_BIT = 0;
  localparam int IRQ_CFG_ERR_BIT = 1;
  localparam int IRQ_FAULT_BIT = 2;
  localparam int IRQ_BT_FAIL_BIT = 3;
  localparam int IRQ_PORT_ERR_BIT = 4;
  localparam logic [IRQ_W-1:0] IRQ_RST = 6'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic bt_ok;
    logic bt_fail;
    logic prog_mode;
    logic diag_fault;
    logic port_cfg_err;
    logic sys_cfg_err;
    logic cfg_block_valid;
    logic [7:0] cfg_block_id;
  } module_status_t;

  typedef struct packed {
    logic tx_byte;
    logic rx_byte;
    logic comm_error;
    logic cts_missing;
    logic slave_fail;
    logic master_recurring;
  } port_status_t;

  typedef struct packed {
    logic activity_led;
    logic fault_led;
    logic config_led;
    logic backplane_fail_led;
    logic port_one_error_led;
    logic port_two_error_led;
    logic port_one_send_led;
    logic port_two_send_led;
    logic port_one_receive_led;
    logic port_two_receive_led;
    logic port_one_traffic_led;
    logic port_two_traffic_led;
  } led_bank_t;

  typedef enum logic [1:0] {
    ACT_NORMAL = 2'b00,
    ACT_PROBLEM = 2'b01,
    ACT_FAIL = 2'b11,
    ACT_PROG = 2'b10
  } act_mode_t;

endpackage

// File: testbench/led_viewer.sv
// Purpose: Operator model that watches the front-panel lamps
// Assumes: Lamps are looked at once per module clock
// Notes: Counts turn-ons and lit cycles of each lamp since the last clear
`timescale 1ns/1ps
`default_nettype none
module led_viewer (
  input wire logic clk_in,
  input wire logic clear_in,
  input wire led_diag_pkg::led_bank_t leds_in,
  output logic [11:0][7:0] rises_out,
  output logic [11:0][7:0] lit_out
);
  logic [11:0] cur;
  logic [11:0] prev;
  assign cur = leds_in;
  always_ff @(posedge clk_in) begin
    prev <= cur;
    for (int i = 0; i < 12; i++) begin
      if (clear_in) begin
        rises_out[i] <= 8'h00;
        lit_out[i] <= 8'h00;
      end else begin
        rises_out[i] <= rises_out[i] + 8'(cur[i] & ~prev[i]);
        lit_out[i] <= lit_out[i] + 8'(cur[i]);
      end
    end
  end
endmodule // led_viewer
`default_nettype wire

// File: testbench/test_led_diag.sv
// Purpose: Self-checking bench for the diagnostic LED block
// Assumes: Short blink parameters; AHB-Lite single word transfers
// Notes: Lamp patterns judged by turn-on and lit counts over a window
`timescale 1ns/1ps
`default_nettype none
module test_led_diag;
  localparam int ix_act = 11;
  localparam int ix_fault = 10;
  localparam int ix_cfg = 9;
  localparam int ix_bp = 8;
  localparam int ix_e1 = 7;
  localparam int ix_e2 = 6;
  localparam int ix_s1 = 5;
  localparam int ix_s2 = 4;
  localparam int ix_r1 = 3;
  localparam int ix_r2 = 2;
  localparam int ix_t1 = 1;
  localparam int ix_t2 = 0;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  led_diag_pkg::module_status_t st = '0;
  led_diag_pkg::port_status_t ps0 = '0;
  led_diag_pkg::port_status_t ps1 = '0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  led_diag_pkg::led_bank_t leds;
  logic irq;
  logic clr = 1'b0;
  logic [11:0][7:0] rises;
  logic [11:0][7:0] lit;
  logic [31:0] rd_data;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [2:0] act_in [4] = '{3'b111, 3'b011, 3'b000, 3'b001};
  int r_lo [4] = '{1, 0, 0, 4};
  int r_hi [4] = '{3, 0, 0, 6};
  int l_lo [4] = '{30, 0, 75, 30};
  int l_hi [4] = '{50, 0, 80, 50};
  int bp [4] = '{1, 1, 0, 0};

  always #50 clk_in = ~clk_in;

  led_diag #(.FAST_HALF(8), .SLOW_HALF(20), .EVENT_ON(3), .EVENT_OFF(3)) DUT (
    .clk_in(clk_in), .rst_in(rst_in), .status_in(st),
    .port_one_in(ps0), .port_two_in(ps1), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .leds_out(leds), .irq_out(irq));

  led_viewer viewer (.clk_in(clk_in), .clear_in(clr), .leds_in(leds),
    .rises_out(rises), .lit_out(lit));

  task end_sim;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      miscompares++;
      end_sim;
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task rng(input string nm, input int lo, input int hi, input logic [7:0] g);
    cmp_count++;
    if (g >= lo && g <= hi) begin
    end else begin
      miscompares++;
      $display("MISMATCH %s expected %0d..%0d seen %h", nm, lo, hi, g);
    end
  endtask

  task wait_ready;
    do @(posedge clk_in); while (hready !== 1'b1);
  endtask

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_in);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= led_diag_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= 3'h2;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready;
    rd_data = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(nm, e, rd_data);
  endtask

  task start_watch;
    @(posedge clk_in) clr <= 1'b1;
    @(posedge clk_in) clr <= 1'b0;
  endtask

  task cfg_block(input logic [7:0] id);
    @(posedge clk_in) begin
      st.cfg_block_valid <= 1'b1;
      st.cfg_block_id <= id;
    end
    @(posedge clk_in) st.cfg_block_valid <= 1'b0;
  endtask

  task port_ev(input int p, input logic [5:0] m);
    @(posedge clk_in) if (p == 0) ps0 <= ps0 | m; else ps1 <= ps1 | m;
    @(posedge clk_in) if (p == 0) ps0 <= ps0 & ~m; else ps1 <= ps1 & ~m;
  endtask

  initial begin
    repeat (16) @(posedge clk_in);
    chk("leds in reset", 32'h0, {20'h0, leds});
    chk("irq in reset", 32'h0, {31'h0, irq});
    rst_in <= 1'b0;
    rdc("ctrl reset", led_diag_pkg::CTRL_OFF, 32'h0);
    rdc("enable reset", led_diag_pkg::IRQ_ENABLE_OFF, 32'h0);
    rdc("status reset", led_diag_pkg::IRQ_STATUS_OFF, 32'h0);
    ahb(1'b1, 8'h14, 32'hffffffff);
    rdc("unmapped", 8'h14, 32'h0);
    // Activity and backplane lamps for one input combination per activity mode
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_in) {st.prog_mode, st.bt_fail, st.bt_ok} <= act_in[k];
      start_watch;
      repeat (80) @(posedge clk_in);
      rng("activity ons", r_lo[k], r_hi[k], rises[ix_act]);
      rng("activity lit", l_lo[k], l_hi[k], lit[ix_act]);
      rng("backplane lit", bp[k] * 75, bp[k] * 80, lit[ix_bp]);
    end
    port_ev(0, 6'h00);
    @(posedge clk_in) st.diag_fault <= 1'b1;
    @(posedge clk_in) st.diag_fault <= 1'b0;
    start_watch;
    repeat (40) @(posedge clk_in);
    rng("fault lit", 38, 40, lit[ix_fault]);
    rng("config idle", 0, 0, lit[ix_cfg]);
    start_watch;
    cfg_block(8'hff);
    cfg_block(8'hff);
    cfg_block(8'h01);
    cfg_block(led_diag_pkg::CFG_BLOCK_ID);
    repeat (40) @(posedge clk_in);
    rng("config flashes", 3, 3, rises[ix_cfg]);
    for (int j = 0; j < 2; j++) begin
      @(posedge clk_in) {st.port_cfg_err, st.sys_cfg_err} <= 2'b01 << j;
      start_watch;
      repeat (20) @(posedge clk_in);
      rng("config err lit", 18, 20, lit[ix_cfg]);
      rng("port err lit", 18, 20, lit[ix_e1]);
    end
    @(posedge clk_in) {st.port_cfg_err, st.sys_cfg_err} <= 2'b00;
    // Separate lamps: sends, receives and errors per port
    start_watch;
    port_ev(0, 6'h20);
    port_ev(0, 6'h20);
    port_ev(1, 6'h10);
    port_ev(0, 6'h08);
    port_ev(0, 6'h08);
    port_ev(1, 6'h20);
    repeat (40) @(posedge clk_in);
    rng("send one", 2, 2, rises[ix_s1]);
    rng("send two", 1, 1, rises[ix_s2]);
    rng("receive one", 0, 0, lit[ix_r1]);
    rng("receive two", 1, 1, rises[ix_r2]);
    rng("traffic dark", 0, 0, lit[ix_t1]);
    rng("error one", 2, 2, rises[ix_e1]);
    rng("error two", 0, 0, lit[ix_e2]);
    ahb(1'b1, led_diag_pkg::CTRL_OFF, 32'h1);
    rdc("ctrl", led_diag_pkg::CTRL_OFF, 32'h1);
    start_watch;
    port_ev(0, 6'h20);
    port_ev(0, 6'h10);
    port_ev(1, 6'h10);
    repeat (40) @(posedge clk_in);
    rng("traffic one", 2, 2, rises[ix_t1]);
    rng("traffic two", 1, 1, rises[ix_t2]);
    rng("send dark", 0, 0, lit[ix_s1]);
    for (int j = 0; j < 3; j++) begin
      @(posedge clk_in) ps1 <= 6'h04 >> j;
      start_watch;
      repeat (20) @(posedge clk_in);
      rng("port two hard", 18, 20, lit[ix_e2]);
    end
    @(posedge clk_in) begin
      ps1 <= '0;
      st.bt_fail <= 1'b1;
    end
    rdc("status events", led_diag_pkg::IRQ_STATUS_OFF, 32'h1f);
    // Interrupt raise, clear and mask
    ahb(1'b1, led_diag_pkg::IRQ_CLEAR_OFF, 32'h3f);
    rdc("status clear", led_diag_pkg::IRQ_STATUS_OFF, 32'h0);
    ahb(1'b1, led_diag_pkg::IRQ_ENABLE_OFF, 32'h10);
    rdc("enable", led_diag_pkg::IRQ_ENABLE_OFF, 32'h10);
    port_ev(0, 6'h08);
    repeat (3) @(posedge clk_in);
    chk("irq raised", 32'h1, {31'h0, irq});
    rdc("status", led_diag_pkg::IRQ_STATUS_OFF, 32'h10);
    ahb(1'b1, led_diag_pkg::IRQ_CLEAR_OFF, 32'h10);
    repeat (2) @(posedge clk_in);
    chk("irq cleared", 32'h0, {31'h0, irq});
    ahb(1'b1, led_diag_pkg::IRQ_ENABLE_OFF, 32'h0);
    port_ev(0, 6'h08);
    port_ev(1, 6'h08);
    repeat (10) @(posedge clk_in);
    chk("irq masked", 32'h0, {31'h0, irq});
    rdc("status masked", led_diag_pkg::IRQ_STATUS_OFF, 32'h30);
    rdc("led state", led_diag_pkg::LED_STATE_OFF, 32'h500);
    end_sim;
  end
endmodule // test_led_diag
`default_nettype wire
